// >>> src/gpc_top.sv
// Pin configuration block with interrupt status behind an AHB-Lite slave
`timescale 1ns/100ps
`include "gpc_regs.svh"

// Contract
// - Per-pin level bit picks high or low as active interrupt level; resets zero.
// - Pin interrupt reaches output only when its enable bit is set.
// - Levels must last over 40 ns to count; source holds them that long.
// - Three-bit field selects serial-ROM data and clock pin function; resets zero.
// - Drive type bit set gives push/pull, clear gives open-drain.
// - Direction bit set makes pin an output, clear an input.
// - Observed receive valid and clocks come from internal PHY; MAC drives transmit enable; both select outputs are low while reset is held.
// - Mux bit clear makes shared LED pin a general pin under these settings.
module gpc_top
    import gpc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset,
    // AHB-Lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // Pins
    input wire logic [2:0] i_pin,
    output logic [2:0] o_pin,
    output logic [2:0] o_pin_oe,
    input wire logic [2:0] i_led,
    // Serial-ROM pin function and PHY observation selects
    output logic [2:0] o_serial_rom_pin_select,
    output logic o_phy_obs_internal,
    output logic o_mac_drives_tx_en,
    // Interrupt
    output logic o_irq
);
    typedef struct packed {
        gpc_phase_e phase;
        logic wr;
        logic [`GPC_ADDR_W-1:0] addr;
        gpc_cfg_s cfg;
        gpc_tri_t irq_status_reg;
        gpc_tri_t pin_irq_enable;
        logic [31:0] rdata;
        gpc_pad_s pad;
        logic irq;
        logic phy_int;
        logic tx_en_mac;
    } gpc_state_s;

    gpc_state_s st_q;
    gpc_state_s st_d;
    gpc_tri_t pin_sync;
    gpc_tri_t pin_filt;
    gpc_tri_t pin_active;
    logic addr_take;

    // Per-pin synchroniser then glitch filter
    for (genvar g = 0; g < `GPC_NPINS; g++) begin : g_pin
        gpc_sync u_sync (
            .i_clock(i_clock),
            .i_reset(i_reset),
            .i_async(i_pin[g]),
            .o_sync(pin_sync[g])
        );
        gpc_filter u_filt (
            .i_clock(i_clock),
            .i_reset(i_reset),
            .i_level(pin_sync[g]),
            .o_level(pin_filt[g])
        );
    end

    // Active level per pin, only for pins in general-purpose input use
    always_comb begin
        for (int k = 0; k < `GPC_NPINS; k++) begin
            pin_active[k] = (pin_filt[k] == st_q.cfg.irq_level[k])
                && !st_q.cfg.mux[k] && !st_q.cfg.direction[k];
        end
    end

    assign addr_take = i_hsel && i_hready && i_htrans[1];

    // Bus, registers, pad and interrupt next state
    always_comb begin
        st_d = st_q;
        // Address phase capture
        if (i_hready) begin
            if (addr_take) begin
                st_d.phase = GPC_DATA;
                st_d.wr = i_hwrite;
                st_d.addr = i_haddr[`GPC_ADDR_W-1:0];
            end else begin
                st_d.phase = GPC_IDLE;
            end
        end
        // Sticky status; set wins over write-one-to-clear
        if (st_q.phase == GPC_DATA && st_q.wr) begin
            case (st_q.addr)
                `GPC_ADDR_CFG: begin
                    st_d.cfg.mux = i_hwdata[`GPC_MUX_LSB +: 3];
                    st_d.cfg.irq_level = i_hwdata[`GPC_POL_LSB +: 3];
                    st_d.cfg.rom_sel = i_hwdata[`GPC_ROM_LSB +: 3];
                    st_d.cfg.drive_type = i_hwdata[`GPC_BUF_LSB +: 3];
                    st_d.cfg.direction = i_hwdata[`GPC_DIR_LSB +: 3];
                end
                `GPC_ADDR_STS: begin
                    st_d.irq_status_reg = st_q.irq_status_reg & ~i_hwdata[2:0];
                end
                `GPC_ADDR_MSK: begin
                    st_d.pin_irq_enable = i_hwdata[2:0];
                end
                `GPC_ADDR_PIN: begin
                    st_d.cfg.out_value = i_hwdata[`GPC_OUT_LSB +: 3];
                end
                default: begin
                    st_d.cfg = st_d.cfg;
                end
            endcase
        end
        st_d.irq_status_reg = st_d.irq_status_reg | pin_active;
        // Read data for the next data phase
        st_d.rdata = '0;
        if (addr_take && !i_hwrite) begin
            case (i_haddr[`GPC_ADDR_W-1:0])
                `GPC_ADDR_CFG: begin
                    st_d.rdata[`GPC_MUX_LSB +: 3] = st_q.cfg.mux;
                    st_d.rdata[`GPC_POL_LSB +: 3] = st_q.cfg.irq_level;
                    st_d.rdata[`GPC_ROM_LSB +: 3] = st_q.cfg.rom_sel;
                    st_d.rdata[`GPC_BUF_LSB +: 3] = st_q.cfg.drive_type;
                    st_d.rdata[`GPC_DIR_LSB +: 3] = st_q.cfg.direction;
                end
                `GPC_ADDR_STS: begin
                    st_d.rdata[2:0] = st_q.irq_status_reg;
                end
                `GPC_ADDR_MSK: begin
                    st_d.rdata[2:0] = st_q.pin_irq_enable;
                end
                `GPC_ADDR_PIN: begin
                    st_d.rdata[`GPC_OUT_LSB +: 3] = st_q.cfg.out_value;
                    st_d.rdata[`GPC_IN_LSB +: 3] = pin_filt;
                end
                default: begin
                    st_d.rdata = '0;
                end
            endcase
        end
        // Pad drive: LED when muxed, else output per direction and type
        for (int k = 0; k < `GPC_NPINS; k++) begin
            if (st_d.cfg.mux[k]) begin
                st_d.pad.out[k] = i_led[k];
                st_d.pad.oe[k] = 1'b1;
            end else if (!st_d.cfg.direction[k]) begin
                st_d.pad.out[k] = 1'b0;
                st_d.pad.oe[k] = 1'b0;
            end else if (st_d.cfg.drive_type[k]) begin
                st_d.pad.out[k] = st_d.cfg.out_value[k];
                st_d.pad.oe[k] = 1'b1;
            end else begin
                st_d.pad.out[k] = 1'b0; // Open-drain pulls low only
                st_d.pad.oe[k] = !st_d.cfg.out_value[k];
            end
        end
        // Level interrupt from unmasked sticky bits
        st_d.irq = |(st_d.irq_status_reg & st_d.pin_irq_enable);
        // Fixed PHY observation and transmit enable ownership
        st_d.phy_int = 1'b1;
        st_d.tx_en_mac = 1'b1;
    end

    // State register
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            st_q <= '0;
            st_q.phase <= GPC_IDLE;
            st_q.cfg.mux <= `GPC_MUX_RST;
            st_q.cfg.irq_level <= `GPC_POL_RST;
            st_q.cfg.rom_sel <= `GPC_ROM_RST;
            st_q.cfg.drive_type <= `GPC_BUF_RST;
            st_q.cfg.direction <= `GPC_DIR_RST;
            st_q.cfg.out_value <= `GPC_OUT_RST;
            st_q.irq_status_reg <= `GPC_STS_RST;
            st_q.pin_irq_enable <= `GPC_MSK_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from flip-flops, apart from tied-off o_hreadyout and o_hresp
    assign o_hrdata = st_q.rdata;
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_pin = st_q.pad.out;
    assign o_pin_oe = st_q.pad.oe;
    assign o_serial_rom_pin_select = st_q.cfg.rom_sel;
    assign o_phy_obs_internal = st_q.phy_int;
    assign o_mac_drives_tx_en = st_q.tx_en_mac;
    assign o_irq = st_q.irq;
endmodule : gpc_top

// >>> include/gpc_regs.svh
// Register offsets, field positions, reset values and timing counts for the pin block
`ifndef GPC_REGS_SVH
`define GPC_REGS_SVH

`define GPC_ADDR_CFG 8'h00
`define GPC_ADDR_STS 8'h04
`define GPC_ADDR_MSK 8'h08
`define GPC_ADDR_PIN 8'h0C
`define GPC_ADDR_W 8

`define GPC_NPINS 3
`define GPC_MUX_LSB 28
`define GPC_POL_LSB 24
`define GPC_ROM_LSB 20
`define GPC_BUF_LSB 16
`define GPC_DIR_LSB 8
`define GPC_OUT_LSB 0
`define GPC_IN_LSB 4

`define GPC_CFG_RST 32'h0000_0000
`define GPC_MUX_RST 3'h0
`define GPC_POL_RST 3'h0
`define GPC_ROM_RST 3'h0
`define GPC_BUF_RST 3'h0
`define GPC_DIR_RST 3'h0
`define GPC_OUT_RST 3'h0
`define GPC_STS_RST 3'h0
`define GPC_MSK_RST 3'h0

// Least pulse width in ns and the clock period in ns
`define GPC_MIN_PULSE_NS 40
`define GPC_CLK_NS 4
// Longer than 40 ns: more than 10 cycles, so 11 stable samples
`define GPC_FILT_CYC ((`GPC_MIN_PULSE_NS / `GPC_CLK_NS) + 1)
`define GPC_FILT_W 4

`endif

// >>> include/gpc_pkg.sv
// Types shared by the pin configuration block
package gpc_pkg;
    typedef logic [2:0] gpc_tri_t;

    // Software-visible configuration of the three pins
    typedef struct packed {
        gpc_tri_t mux;
        gpc_tri_t irq_level;
        logic [2:0] rom_sel;
        gpc_tri_t drive_type;
        gpc_tri_t direction;
        gpc_tri_t out_value;
    } gpc_cfg_s;

    // Pin driver controls going out
    typedef struct packed {
        gpc_tri_t out;
        gpc_tri_t oe;
    } gpc_pad_s;

    // Bus slave state
    typedef enum logic [1:0] {
        GPC_IDLE = 2'h0,
        GPC_DATA = 2'h1
    } gpc_phase_e;
endpackage : gpc_pkg

// >>> src/gpc_filter.sv
// Glitch filter for one synchronised pin level
`timescale 1ns/100ps
`include "gpc_regs.svh"

module gpc_filter
    import gpc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_level,
    output logic o_level
);
    typedef struct packed {
        logic [`GPC_FILT_W-1:0] cnt;
        logic filt;
    } gpc_filt_s;

    gpc_filt_s st_q;
    gpc_filt_s st_d;

    // Count steady cycles of a new level, adopt it after the minimum width
    always_comb begin
        st_d = st_q;
        if (i_level == st_q.filt) begin
            st_d.cnt = '0;
        end else if (st_q.cnt == `GPC_FILT_W'(`GPC_FILT_CYC - 1)) begin
            st_d.filt = i_level;
            st_d.cnt = '0;
        end else begin
            st_d.cnt = st_q.cnt + `GPC_FILT_W'(1);
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_level = st_q.filt;
endmodule : gpc_filter

// >>> src/gpc_sync.sv
// Two-stage synchroniser for one pin input
`timescale 1ns/100ps

module gpc_sync
    import gpc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_async,
    output logic o_sync
);
    typedef struct packed {
        logic meta;
        logic stable;
    } gpc_sync_s;

    gpc_sync_s st_q;
    gpc_sync_s st_d;

    // First stage feeds only the second
    always_comb begin
        st_d.meta = i_async;
        st_d.stable = st_q.meta;
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_sync = st_q.stable;
endmodule : gpc_sync

// >>> test/gpc_top_sva.sv
// Checker for the pin block ports
`timescale 1ns/100ps
`include "gpc_regs.svh"
module gpc_top_sva
    import gpc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    input wire logic [2:0] i_pin,
    input wire logic [2:0] o_pin,
    input wire logic [2:0] o_pin_oe,
    input wire logic [2:0] o_serial_rom_pin_select,
    input wire logic o_phy_obs_internal,
    input wire logic o_mac_drives_tx_en,
    input wire logic o_irq
);
    logic dw_q;
    logic [7:0] da_q;
    logic [31:0] cfg_q;
    logic [2:0] val_q, pin_q, age_q;
    logic [3:0] long_q;
    logic [3:0] run_q [3];
    wire logic [2:0] pp = ~cfg_q[30:28] & cfg_q[10:8] & cfg_q[18:16];
    wire logic [2:0] od = ~cfg_q[30:28] & cfg_q[10:8] & ~cfg_q[18:16];
    // Shadow of written setup, age of last write, pin stable runs
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            dw_q <= 1'b0;
            cfg_q <= '0;
            val_q <= 3'h0;
            age_q <= 3'h7;
            long_q <= 4'hF;
            run_q <= '{default: 4'h0};
        end else begin
            dw_q <= i_hsel & i_hready & i_htrans[1] & i_hwrite;
            cfg_q <= (dw_q && da_q == `GPC_ADDR_CFG) ? i_hwdata : cfg_q;
            val_q <= (dw_q && da_q == `GPC_ADDR_PIN) ? i_hwdata[2:0] : val_q;
            age_q <= dw_q ? 3'h0 : age_q + 3'(age_q != 3'h7);
            // Restart when some pin has just completed ten steady cycles
            long_q <= (run_q[0] == 4'hA || run_q[1] == 4'hA || run_q[2] == 4'hA) ? 4'h0
                : long_q + 4'(long_q != 4'hF);
            for (int k = 0; k < 3; k++) begin
                run_q[k] <= (i_pin[k] != pin_q[k]) ? 4'h0 : run_q[k] + 4'(run_q[k] != 4'hF);
            end
        end
        da_q <= i_haddr[7:0];
        pin_q <= i_pin;
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);
    sequence s_settled;
        age_q > 3'h2;
    endsequence
    property p_phy;
        !$past(i_reset) |-> o_phy_obs_internal && o_mac_drives_tx_en;
    endproperty
    a_phy: assert property (p_phy) else $error("phy outputs low");
    property p_rom;
        s_settled |-> o_serial_rom_pin_select == cfg_q[22:20];
    endproperty
    a_rom: assert property (p_rom) else $error("rom select differs");
    property p_input;
        s_settled |-> (o_pin_oe & ~cfg_q[30:28] & ~cfg_q[10:8]) == 3'h0;
    endproperty
    a_input: assert property (p_input) else $error("input pin driven");
    property p_push;
        s_settled |-> (o_pin_oe & pp) == pp && (o_pin & pp) == (val_q & pp);
    endproperty
    a_push: assert property (p_push) else $error("push pull wrong");
    property p_drain;
        s_settled |-> (o_pin_oe & od) == (~val_q & od) && (o_pin & o_pin_oe & od) == 3'h0;
    endproperty
    a_drain: assert property (p_drain) else $error("open drain wrong");
    property p_led;
        s_settled |-> (o_pin_oe & cfg_q[30:28]) == cfg_q[30:28];
    endproperty
    a_led: assert property (p_led) else $error("led pin not driven");
    property p_irq_fall;
        $fell(o_irq) |-> age_q < 3'h4;
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
    property p_irq_rise;
        $rose(o_irq) |-> age_q < 3'h4 || long_q < 4'h9;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq on short level");
endmodule : gpc_top_sva

bind gpc_top gpc_top_sva i_sva (.i_clock, .i_reset, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
    .i_hwdata, .i_hready, .i_pin, .o_pin, .o_pin_oe, .o_serial_rom_pin_select,
    .o_phy_obs_internal, .o_mac_drives_tx_en, .o_irq);

// >>> test/gpio_pin_configuration_test.sv
// Self-checking bench for the pin configuration block
`timescale 1ns/100ps
`include "gpc_regs.svh"
module gpio_pin_configuration_test import gpc_pkg::*;;
    logic i_clock = 1'b0, i_reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = '0, hwdata = '0, o_hrdata, rd, cfg;
    logic [2:0] pin = 3'h0, led = 3'h0, o_pin, o_pin_oe, rom, lvl, val;
    logic o_hreadyout, o_hresp, phy, txen, o_irq;
    int failures = 0, n_tests = 0, seed = 70946;
    logic [31:0] corner [3] = '{32'h0007_0700, 32'h0000_0700, 32'h7001_0000};
    always #2 i_clock = ~i_clock;
    gpc_top i_dut (.i_clock, .i_reset, .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(o_hreadyout),
        .o_hrdata, .o_hreadyout, .o_hresp, .i_pin(pin), .o_pin, .o_pin_oe, .i_led(led),
        .o_serial_rom_pin_select(rom), .o_phy_obs_internal(phy), .o_mac_drives_tx_en(txen),
        .o_irq);
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Bounded wait for hready at a rising edge
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_hreadyout !== 1'b1 && n < 50);
        if (o_hreadyout !== 1'b1) begin
            failures++;
            end_of_test();
        end
    endtask : wait_ready
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = o_hrdata;
    endtask : bus
    // Expected drive enables and driven levels
    function automatic logic [5:0] pads(input logic [31:0] c, input logic [2:0] v, l);
        logic [2:0] oe, out;
        for (int k = 0; k < 3; k++) begin
            oe[k] = c[28+k] | (c[8+k] & (c[16+k] | ~v[k]));
            out[k] = c[28+k] ? l[k] : c[8+k] & c[16+k] & v[k];
        end
        return {oe, out & oe};
    endfunction : pads
    initial begin
        repeat (4) @(posedge i_clock);
        i_reset <= 1'b0;
        // An ignored write to an unmapped place, then the reset contents
        bus(1'b1, 8'h10, 32'hFFFF_FFFF);
        for (int a = 0; a < 5; a++) begin
            bus(1'b0, 8'(a * 4), 32'h0);
            check(rd, (a == 1) ? 32'h7 : 32'h0);
        end
        check({29'h0, rom}, 32'h0);
        check({29'h0, o_hresp, phy, txen}, 32'h3);
        // Corner and random setups read back and seen at the pads
        for (int i = 0; i < 10; i++) begin
            cfg = (i < 3) ? corner[i] : $random(seed) & 32'h7737_0700;
            val = 3'($random(seed));
            led <= 3'($random(seed));
            bus(1'b1, `GPC_ADDR_CFG, cfg);
            bus(1'b1, `GPC_ADDR_PIN, {29'h0, val});
            bus(1'b0, `GPC_ADDR_CFG, 32'h0);
            check(rd, cfg);
            check({29'h0, rom}, {29'h0, cfg[22:20]});
            check({26'h0, o_pin_oe, o_pin & o_pin_oe}, {26'h0, pads(cfg, val, led)});
        end
        // Level interrupts per pin, both polarities, short pulse ignored
        for (int k = 0; k < 3; k++) begin
            lvl = 3'($random(seed));
            lvl[k] = k[0];
            pin <= ~lvl;
            bus(1'b1, `GPC_ADDR_CFG, {5'h0, lvl, 24'h0});
            bus(1'b1, `GPC_ADDR_MSK, 32'h0);
            repeat (20) @(posedge i_clock);
            bus(1'b1, `GPC_ADDR_STS, 32'h7);
            pin[k] <= lvl[k];
            repeat (6) @(posedge i_clock);
            pin[k] <= ~lvl[k];
            repeat (20) @(posedge i_clock);
            bus(1'b0, `GPC_ADDR_STS, 32'h0);
            check(rd, 32'h0);
            pin[k] <= lvl[k];
            repeat (20) @(posedge i_clock);
            bus(1'b0, `GPC_ADDR_STS, 32'h0);
            check(rd, 32'(1 << k));
            check({31'h0, o_irq}, 32'h0);
            bus(1'b1, `GPC_ADDR_MSK, 32'(1 << k));
            repeat (3) @(posedge i_clock);
            check({31'h0, o_irq}, 32'h1);
            pin[k] <= ~lvl[k];
            repeat (20) @(posedge i_clock);
            bus(1'b1, `GPC_ADDR_STS, 32'h7);
            repeat (3) @(posedge i_clock);
            check({31'h0, o_irq}, 32'h0);
            pin[k] <= lvl[k];
            repeat (20) @(posedge i_clock);
            check({31'h0, o_irq}, 32'h1);
        end
        end_of_test();
    end
endmodule : gpio_pin_configuration_test
